// ===== hw/vtsr_pkg.sv
// Package: constants, field layouts and types for the vertical timing and sound rate block
package vtsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus word layout
  localparam int unsigned SEL_MSB      = 31;
  localparam int unsigned SEL_LSB      = 24;
  localparam int unsigned VF_MSB       = 23;
  localparam int unsigned VF_LSB       = 14;
  localparam int unsigned SND_MSB      = 8;
  localparam int unsigned SND_LSB      = 0;
  localparam int unsigned CTL_MSB      = 15;
  localparam int unsigned CTL_LSB      = 0;
  localparam int unsigned VW           = 10;
  localparam int unsigned SND_W        = 9;
  localparam int unsigned CTL_W        = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register selects carried in the top byte
  localparam logic [7:0] OFS_FRAME_RASTER_PERIOD      = 8'hA0;
  localparam logic [7:0] OFS_VERTICAL_SYNC_WIDTH      = 8'hA4;
  localparam logic [7:0] OFS_VERTICAL_BORDER_BEGIN    = 8'hA8;
  localparam logic [7:0] OFS_VERTICAL_DISPLAY_BEGIN   = 8'hAC;
  localparam logic [7:0] OFS_VERTICAL_DISPLAY_FINISH  = 8'hB0;
  localparam logic [7:0] OFS_VERTICAL_BORDER_FINISH   = 8'hB4;
  localparam logic [7:0] OFS_VERTICAL_POINTER_BEGIN   = 8'hB8;
  localparam logic [7:0] OFS_VERTICAL_POINTER_FINISH  = 8'hBC;
  localparam logic [7:0] OFS_AUDIO_SAMPLE_PERIOD      = 8'hC0;
  localparam logic [7:0] OFS_OPERATING_MODE_CONTROL   = 8'hE0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the sound and control registers, and the split width of the raster counter
  localparam int unsigned SND_PERIOD_MSB = 7;
  localparam int unsigned SND_RUN_BIT    = 8;
  localparam int unsigned CTL_DMA_LSB    = 4;
  localparam int unsigned CTL_DMA_MSB    = 5;
  localparam int unsigned CTL_INTERLACE  = 6;
  localparam int unsigned CTL_COMPOSITE  = 7;
  localparam int unsigned CTL_DAC_TEST   = 8;
  localparam int unsigned CTL_TEST_LO    = 14;
  localparam int unsigned CTL_TEST_HI    = 15;
  localparam int unsigned SPLIT_W        = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [VW-1:0]    VREG_RESET = 10'h000;
  localparam logic [SND_W-1:0] SND_RESET  = 9'h000;
  localparam logic [CTL_W-1:0] CTL_RESET  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one microsecond of REF_CLK cycles split into eighths
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned MICROSEC_NS        = 1000;
  localparam int unsigned CYC_PER_US         = MICROSEC_NS / CLK_PERIOD_NS;
  localparam int unsigned EIGHTHS_PER_BYTE   = 8;
  localparam int unsigned CYC_PER_EIGHTH_US  = CYC_PER_US / EIGHTHS_PER_BYTE;
  localparam int unsigned PHASE_W            = 11;

  // Counter test modes decoded from control bits 15:14
  typedef enum logic [1:0] {
    TM_NORMAL,
    TM_HCOUNT,
    TM_VLOW,
    TM_VHIGH
  } vtsr_test_type;

endpackage

// ===== hw/vtsr_win_if.sv
// Interface: raster count and limits shared with each window generator
`timescale 1ns/10ps
interface vtsr_win_if;
  import vtsr_pkg::*;
  logic [VW-1:0] count;
  logic          hold;
  logic [VW-1:0] start_v;
  logic [VW-1:0] end_v;
  logic          active;

  modport win (
    input  count,
    input  hold,
    input  start_v,
    input  end_v,
    output active
  );

  modport ctl (
    output count,
    output hold,
    output start_v,
    output end_v,
    input  active
  );
endinterface

// ===== hw/vtsr_window.sv
// Module: one raster window that switches on and off at programmed raster counts
`timescale 1ns/10ps
module vtsr_window (
  input wire logic clk,
  input wire logic srst,
  vtsr_win_if.win  w
);
  import vtsr_pkg::*;

  typedef struct packed {
    logic active;
  } vtsr_win_state_type;

  vtsr_win_state_type st_q;
  vtsr_win_state_type st_d;
  logic [VW:0]        on_at;
  logic [VW:0]        off_at;
  logic [VW:0]        cnt_x;

  ////////////////////////////////////////////////////////////////////////////
  // Match counts: value plus one is the raster where the edge falls
  always_comb begin
    on_at  = {1'b0, w.start_v} + {{VW{1'b0}}, 1'b1};
    off_at = {1'b0, w.end_v} + {{VW{1'b0}}, 1'b1};
    cnt_x  = {1'b0, w.count};
    st_d   = st_q;
    if (w.hold) begin
      st_d.active = 1'b0;
    end else if (cnt_x == off_at) begin
      st_d.active = 1'b0;
    end else if (cnt_x == on_at) begin
      st_d.active = 1'b1;
    end else if (w.count == VREG_RESET) begin
      st_d.active = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign w.active = st_q.active;
endmodule

// ===== hw/vtsr_sound.sv
// Module: sound byte rate timer with an eighth-of-period tick for test output
`timescale 1ns/10ps
module vtsr_sound (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       hold,
  input  wire logic [7:0] period,
  input  wire logic       test8,
  output logic            byte_tick,
  output logic            stereo
);
  import vtsr_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [2:0]         eighth;
    logic               tick;
    logic               lr;
    logic               pulse8;
  } vtsr_snd_state_type;

  vtsr_snd_state_type st_q;
  vtsr_snd_state_type st_d;
  logic [PHASE_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // Period plus one microseconds, split into eight equal phases
  always_comb begin
    limit = PHASE_W'(({3'b000, period} + 11'h001) * PHASE_W'(CYC_PER_EIGHTH_US)) - 11'h001;
    st_d        = st_q;
    st_d.tick   = 1'b0;
    st_d.pulse8 = 1'b0;
    if (hold) begin
      st_d = '0;
    end else if (st_q.phase >= limit) begin
      st_d.phase  = '0;
      st_d.eighth = st_q.eighth + 3'h1;
      st_d.pulse8 = 1'b1;
      if (st_q.eighth == 3'h7) begin
        st_d.tick = 1'b1;
        st_d.lr   = ~st_q.lr;
      end
    end else begin
      st_d.phase = st_q.phase + 11'h001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign byte_tick = st_q.tick;
  assign stereo    = test8 ? st_q.pulse8 : st_q.lr;
endmodule

// ===== hw/vtsr_top.sv
// Module: vertical raster timing, sound byte rate and mode control
`timescale 1ns/10ps
module vtsr_top (
  input  wire logic                   REF_CLK,
  input  wire logic                   SRST,
  input  wire logic                   REG_WR,
  input  wire logic [31:0]            REG_WDATA,
  input  wire logic                   RASTER_START,
  input  wire logic                   HSYNC_N,
  input  wire logic                   VIDEO_BYTE_HALF,
  input  wire logic [2:0]             VIDEO_WORD,
  input  wire logic                   VIDEO_DMA_ACK,
  input  wire logic [3:0]             SOUND_BYTE,
  input  wire logic [3:0]             GREEN_DAC,
  input  wire logic [3:0]             BLUE_DAC,
  input  wire logic                   DAC_OBSERVE_SELECT,
  output logic                        VERT_SYNC_N,
  output logic                        V_CSYNC_N,
  output logic                        BORDER_ON,
  output logic                        DISPLAY_ON,
  output logic                        CURSOR_ON,
  output logic [vtsr_pkg::VW-1:0]     RASTER_COUNT,
  output logic                        ODD_FIELD,
  output logic                        INTERLACE_ON,
  output logic                        HCOUNT_TEST_STEP,
  output logic                        VIDEO_DMA_REQUEST_N,
  output logic                        SOUND_BYTE_STROBE,
  output logic                        STEREO_POSITION,
  output logic [3:0]                  SOUND_DATA_PINS
);
  import vtsr_pkg::*;

  typedef struct packed {
    logic [VW-1:0]    frame;
    logic [VW-1:0]    vsw;
    logic [VW-1:0]    bbeg;
    logic [VW-1:0]    dbeg;
    logic [VW-1:0]    dfin;
    logic [VW-1:0]    bfin;
    logic [VW-1:0]    pbeg;
    logic [VW-1:0]    pfin;
    logic [SND_W-1:0] snd;
    logic [CTL_W-1:0] ctl;
    logic [VW-1:0]    count;
    logic             field;
    logic             vsync;
    logic             csync_n;
    logic             dma_n;
    logic             hstep;
    logic             sel_meta;
    logic             sel_sync;
    logic [3:0]       sdata;
  } vtsr_state_type;

  vtsr_state_type st_q;
  vtsr_state_type st_d;
  vtsr_test_type  mode;
  logic           hold;
  logic [VW-1:0]  wval;
  logic [7:0]     sel;
  logic [VW-1:0]  limit;
  logic           byte_tick;
  logic           stereo;

  vtsr_win_if border_if ();
  vtsr_win_if display_if ();
  vtsr_win_if cursor_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the write word, test mode and the timing hold
  always_comb begin
    sel  = REG_WDATA[SEL_MSB:SEL_LSB];
    wval = REG_WDATA[VF_MSB:VF_LSB];
    hold = ~st_q.snd[SND_RUN_BIT];
    unique case ({st_q.ctl[CTL_TEST_HI], st_q.ctl[CTL_TEST_LO]})
      2'b01:   mode = TM_HCOUNT;
      2'b10:   mode = TM_VLOW;
      2'b11:   mode = TM_VHIGH;
      default: mode = TM_NORMAL;
    endcase
    // Interlace: second field runs one raster longer than the first
    limit = st_q.frame + {{(VW-1){1'b0}}, st_q.ctl[CTL_INTERLACE] & st_q.field};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: registers, raster counter, sync, request and pin data
  always_comb begin
    st_d = st_q;
    // Write-only register file selected by the top byte
    if (REG_WR) begin
      unique case (sel)
        OFS_FRAME_RASTER_PERIOD:     st_d.frame = wval;
        OFS_VERTICAL_SYNC_WIDTH:     st_d.vsw   = wval;
        OFS_VERTICAL_BORDER_BEGIN:   st_d.bbeg  = wval;
        OFS_VERTICAL_DISPLAY_BEGIN:  st_d.dbeg  = wval;
        OFS_VERTICAL_DISPLAY_FINISH: st_d.dfin  = wval;
        OFS_VERTICAL_BORDER_FINISH:  st_d.bfin  = wval;
        OFS_VERTICAL_POINTER_BEGIN:  st_d.pbeg  = wval;
        OFS_VERTICAL_POINTER_FINISH: st_d.pfin  = wval;
        OFS_AUDIO_SAMPLE_PERIOD:     st_d.snd   = REG_WDATA[SND_MSB:SND_LSB];
        OFS_OPERATING_MODE_CONTROL:  st_d.ctl   = REG_WDATA[CTL_MSB:CTL_LSB];
        default:                     st_d.frame = st_q.frame;
      endcase
    end

    // Select pin synchroniser
    st_d.sel_meta = DAC_OBSERVE_SELECT;
    st_d.sel_sync = st_q.sel_meta;

    // Raster counter and its test modes
    st_d.hstep = 1'b0;
    if (hold) begin
      st_d.count = VREG_RESET;
      st_d.field = 1'b0;
    end else begin
      unique case (mode)
        TM_VLOW: begin
          st_d.count[SPLIT_W-1:0] = st_q.count[SPLIT_W-1:0] + 5'h01;
        end
        TM_VHIGH: begin
          st_d.count[VW-1:SPLIT_W] = st_q.count[VW-1:SPLIT_W] + 5'h01;
        end
        TM_NORMAL, TM_HCOUNT: begin
          st_d.hstep = (mode == TM_HCOUNT);
          if (RASTER_START) begin
            if (st_q.count >= limit) begin
              st_d.count = VREG_RESET;
              st_d.field = st_q.ctl[CTL_INTERLACE] & ~st_q.field;
            end else begin
              st_d.count = st_q.count + 10'h001;
            end
          end
        end
      endcase
    end

    // Vertical sync spans counts zero to width inclusive
    st_d.vsync = ~hold & (st_q.count <= st_q.vsw);
    if (st_q.ctl[CTL_COMPOSITE]) begin
      st_d.csync_n = ~((~st_q.vsync) ^ HSYNC_N);
    end else begin
      st_d.csync_n = ~st_q.vsync;
    end

    // Video request: raised at chosen word, dropped by first acknowledge
    if (hold | st_q.vsync) begin
      st_d.dma_n = 1'b1;
    end else if (VIDEO_BYTE_HALF && (VIDEO_WORD[1:0] == st_q.ctl[CTL_DMA_MSB:CTL_DMA_LSB])) begin
      st_d.dma_n = 1'b0;
    end else if (VIDEO_DMA_ACK) begin
      st_d.dma_n = 1'b1;
    end

    // Sound pins: normal data or inverted DAC observation
    if (st_q.ctl[CTL_DAC_TEST]) begin
      st_d.sdata = st_q.sel_sync ? ~BLUE_DAC : ~GREEN_DAC;
    end else begin
      st_d.sdata = SOUND_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      st_q       <= '0;
      st_q.frame <= VREG_RESET;
      st_q.snd   <= SND_RESET;
      st_q.ctl   <= CTL_RESET;
      st_q.dma_n <= 1'b1;
      st_q.csync_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window generators for border, display and cursor
  assign border_if.count    = st_q.count;
  assign border_if.hold     = hold;
  assign border_if.start_v  = st_q.bbeg;
  assign border_if.end_v    = st_q.bfin;
  assign display_if.count   = st_q.count;
  assign display_if.hold    = hold;
  assign display_if.start_v = st_q.dbeg;
  assign display_if.end_v   = st_q.dfin;
  assign cursor_if.count    = st_q.count;
  assign cursor_if.hold     = hold;
  assign cursor_if.start_v  = st_q.pbeg;
  assign cursor_if.end_v    = st_q.pfin;

  vtsr_window u_border (
    .clk  (REF_CLK),
    .srst (SRST),
    .w    (border_if.win)
  );

  vtsr_window u_display (
    .clk  (REF_CLK),
    .srst (SRST),
    .w    (display_if.win)
  );

  vtsr_window u_cursor (
    .clk  (REF_CLK),
    .srst (SRST),
    .w    (cursor_if.win)
  );

  // Sound byte timer
  vtsr_sound u_sound (
    .clk       (REF_CLK),
    .srst      (SRST),
    .hold      (hold),
    .period    (st_q.snd[SND_PERIOD_MSB:0]),
    .test8     (st_q.ctl[CTL_DAC_TEST]),
    .byte_tick (byte_tick),
    .stereo    (stereo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign VERT_SYNC_N         = ~st_q.vsync;
  assign V_CSYNC_N           = st_q.csync_n;
  assign BORDER_ON           = border_if.active;
  assign DISPLAY_ON          = display_if.active;
  assign CURSOR_ON           = cursor_if.active;
  assign RASTER_COUNT        = st_q.count;
  assign ODD_FIELD           = st_q.field;
  assign INTERLACE_ON        = st_q.ctl[CTL_INTERLACE];
  assign HCOUNT_TEST_STEP    = st_q.hstep;
  assign VIDEO_DMA_REQUEST_N = st_q.dma_n;
  assign SOUND_BYTE_STROBE   = byte_tick;
  assign STEREO_POSITION     = stereo;
  assign SOUND_DATA_PINS     = st_q.sdata;
endmodule

// ===== tb/vtsr_properties.sv
// Checker: pin-level timing relations of the vertical timing block
`timescale 1ns/10ps
module vtsr_props (
  input logic                    REF_CLK,
  input logic                    SRST,
  input logic                    REG_WR,
  input logic [31:0]             REG_WDATA,
  input logic                    RASTER_START,
  input logic                    HSYNC_N,
  input logic                    VIDEO_BYTE_HALF,
  input logic [2:0]              VIDEO_WORD,
  input logic                    VIDEO_DMA_ACK,
  input logic                    VERT_SYNC_N,
  input logic                    V_CSYNC_N,
  input logic                    BORDER_ON,
  input logic                    DISPLAY_ON,
  input logic                    CURSOR_ON,
  input logic [vtsr_pkg::VW-1:0] RASTER_COUNT,
  input logic                    HCOUNT_TEST_STEP,
  input logic                    VIDEO_DMA_REQUEST_N,
  input logic                    SOUND_BYTE_STROBE
);
  import vtsr_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  logic [15:0] rg_q [32];
  logic [3:0]  ex_q;
  logic        okp_q;
  logic        cm_q;
  logic        seen_q;
  int          gap_q;
  wire  [4:0]  ix   = REG_WDATA[30:26];
  wire         wsel = REG_WR && REG_WDATA[31] && REG_WDATA[25:24] == 2'b00;
  wire  [15:0] rw   = {6'h00, RASTER_COUNT};
  wire         run  = rg_q[16][8];
  wire         ok   = run && rg_q[24][15:14] == 2'b00;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow registers and expected levels one clock behind
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 32; i++) begin
        rg_q[i] <= 16'h0000;
      end
      ex_q   <= 4'h0;
      okp_q  <= 1'b0;
      cm_q   <= 1'b0;
      seen_q <= 1'b0;
      gap_q  <= 0;
    end else begin
      if (wsel) begin
        rg_q[ix] <= ix < 5'd16 ? {6'h00, REG_WDATA[23:14]} : ix == 5'd16 ? {7'h00, REG_WDATA[8:0]} : REG_WDATA[15:0];
      end
      ex_q   <= {run && rw <= rg_q[9], run && rw > rg_q[10] && rw <= rg_q[13],
                 run && rw > rg_q[11] && rw <= rg_q[12], run && rw > rg_q[14] && rw <= rg_q[15]};
      okp_q  <= ok;
      cm_q   <= rg_q[24][7];
      seen_q <= (seen_q || SOUND_BYTE_STROBE) && run && !(wsel && ix == 5'd16);
      gap_q  <= SOUND_BYTE_STROBE ? 1 : gap_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_sync_width: assert property (okp_q && ok |-> VERT_SYNC_N == !ex_q[3])
    else $error("vertical sync level wrong");
  a_border_win: assert property (okp_q && ok |-> BORDER_ON == ex_q[2])
    else $error("border window wrong");
  a_display_win: assert property (okp_q && ok |-> DISPLAY_ON == ex_q[1])
    else $error("display window wrong");
  a_cursor_win: assert property (okp_q && ok |-> CURSOR_ON == ex_q[0])
    else $error("cursor window wrong");
  a_count_step: assert property (ok && !rg_q[24][6] && RASTER_START |=>
    RASTER_COUNT == ($past(rw) == rg_q[8] ? 10'h000 : $past(RASTER_COUNT) + 10'h001))
    else $error("raster count step wrong");
  a_count_idle: assert property (ok && !RASTER_START |=> $stable(RASTER_COUNT))
    else $error("raster count moved without raster");
  a_held_clear: assert property (!run ##1 !run |-> rw == 16'h0000 && VERT_SYNC_N && !DISPLAY_ON)
    else $error("timing not held while run bit low");
  a_csync_form: assert property ($stable(HSYNC_N) && $stable(VERT_SYNC_N) && cm_q == rg_q[24][7]
    |-> V_CSYNC_N == (cm_q ? !(VERT_SYNC_N ^ HSYNC_N) : VERT_SYNC_N))
    else $error("sync pin form wrong");
  a_dma_set: assert property (run && VERT_SYNC_N && VIDEO_BYTE_HALF && VIDEO_WORD[1:0] == rg_q[24][5:4]
    |=> !VIDEO_DMA_REQUEST_N)
    else $error("video request not raised");
  a_dma_ack: assert property (!VIDEO_DMA_REQUEST_N && VIDEO_DMA_ACK && !VIDEO_BYTE_HALF |=> VIDEO_DMA_REQUEST_N)
    else $error("video request not dropped");
  a_sound_gap: assert property (SOUND_BYTE_STROBE && seen_q |-> gap_q == (rg_q[16][7:0] + 1) * CYC_PER_US)
    else $error("sound period wrong");
  a_hcount_step: assert property (rg_q[24][15:14] == 2'b01 ##1 rg_q[24][15:14] == 2'b01 |-> HCOUNT_TEST_STEP)
    else $error("horizontal test step missing");
  c_vsync: cover property (!VERT_SYNC_N ##1 VERT_SYNC_N);
  c_sound: cover property (SOUND_BYTE_STROBE && seen_q);
  c_dma: cover property ($fell(VIDEO_DMA_REQUEST_N));
endmodule
bind vtsr_top vtsr_props u_props (.*);

// ===== tb/vtsr_monitor.sv
// Partner model: raster display making line pulses and counting rows
`timescale 1ns/10ps
module vtsr_monitor #(
  parameter int RL = 8
) (
  input  logic clk,
  input  logic vsync_n,
  input  logic disp,
  output logic rs,
  output logic hs_n,
  output int   sync_rows,
  output int   frame_rows,
  output int   disp_rows
);
  int   ph = 0;
  int   sc = 0;
  int   fc = 0;
  int   dc = 0;
  logic vs_last = 1'b1;
  // Idle line outputs at time zero
  initial begin
    rs = 1'b0;
    hs_n = 1'b1;
  end
  // Line pulse and horizontal sync, changed off the sampling edge
  always @(negedge clk) begin
    ph = (ph + 1) % RL;
    rs <= ph == 0;
    hs_n <= ph > 2;
  end
  // Row counts published at each new frame
  always @(posedge clk) begin
    if (rs) begin
      if (!vsync_n && vs_last) begin
        frame_rows <= fc;
        sync_rows <= sc;
        disp_rows <= dc;
        fc = 0;
        sc = 0;
        dc = 0;
      end
      fc = fc + 1;
      sc = sc + !vsync_n;
      dc = dc + disp;
      vs_last = vsync_n;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Testbench: register write sequences with checked raster and sound results
`timescale 1ns/10ps
module tb_top;
  import vtsr_pkg::*;
  logic REF_CLK = 0, SRST = 1, REG_WR = 0, VIDEO_BYTE_HALF = 0, VIDEO_DMA_ACK = 0, DAC_OBSERVE_SELECT = 0;
  logic [31:0] REG_WDATA = 32'h0000_0000;
  logic [2:0] VIDEO_WORD = 3'h0;
  logic [3:0] SOUND_BYTE = 4'h6, GREEN_DAC = 4'h5, BLUE_DAC = 4'hC, SOUND_DATA_PINS;
  logic RASTER_START, HSYNC_N, VERT_SYNC_N, V_CSYNC_N, BORDER_ON, DISPLAY_ON, CURSOR_ON, ODD_FIELD;
  logic INTERLACE_ON, HCOUNT_TEST_STEP, VIDEO_DMA_REQUEST_N, SOUND_BYTE_STROBE, STEREO_POSITION;
  logic [VW-1:0] RASTER_COUNT, rc0;
  int n_fail = 0, tests_run = 0, sr, fr, dr, gap, nst;
  logic [9:0] cf [2][8] = '{'{10'h009, 10'h001, 10'h002, 10'h002, 10'h005, 10'h005, 10'h003, 10'h004},
                            '{10'h006, 10'h000, 10'h000, 10'h001, 10'h005, 10'h005, 10'h002, 10'h003}};
  vtsr_top uut (.*);
  vtsr_monitor #(.RL(8)) mon (.clk(REF_CLK), .vsync_n(VERT_SYNC_N), .disp(DISPLAY_ON), .rs(RASTER_START),
    .hs_n(HSYNC_N), .sync_rows(sr), .frame_rows(fr), .disp_rows(dr));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #12.5 REF_CLK = ~REF_CLK;
  initial begin
    #(25 * 90000);
    n_fail++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] sel, input logic [23:0] val);
    @(negedge REF_CLK);
    REG_WR = 1;
    REG_WDATA = {sel, val};
    @(negedge REF_CLK);
    REG_WR = 0;
  endtask
  task automatic pulse(input logic [2:0] w, input logic a, input logic exp);
    @(negedge REF_CLK);
    VIDEO_WORD = w;
    VIDEO_BYTE_HALF = !a;
    VIDEO_DMA_ACK = a;
    @(negedge REF_CLK);
    VIDEO_BYTE_HALF = 0;
    VIDEO_DMA_ACK = 0;
    chk(VIDEO_DMA_REQUEST_N, exp);
  endtask
  task automatic gap_meas(output int g, output int s);
    g = 0;
    s = 0;
    while (SOUND_BYTE_STROBE !== 1'b1 && g < 20000) begin
      @(negedge REF_CLK);
      g++;
    end
    g = 0;
    do begin
      @(negedge REF_CLK);
      g++;
      s += (STEREO_POSITION === 1'b1);
    end while (SOUND_BYTE_STROBE !== 1'b1 && g < 20000);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(negedge REF_CLK);
    SRST = 0;
    chk({VERT_SYNC_N, V_CSYNC_N, VIDEO_DMA_REQUEST_N, DISPLAY_ON, RASTER_COUNT}, 14'h3800);
    for (int c = 0; c < 2; c++) begin
      wr(8'hC0, 24'h00_0002);
      repeat (4) @(negedge REF_CLK);
      chk({VERT_SYNC_N, RASTER_COUNT}, 11'h400);
      for (int i = 0; i < 8; i++) begin
        wr(8'hA0 + 8'(4 * i), {cf[c][i], 14'h2aaa});
      end
      wr(8'hA2, 24'hFF_FFFF);
      wr(8'hE0, c ? 24'h00_0080 : 24'h00_0000);
      wr(8'hC0, 24'h00_0102);
      repeat (400) @(negedge REF_CLK);
      chk(fr, cf[c][0] + 1);
      chk(sr, cf[c][1] + 1);
      chk(dr, cf[c][4] - cf[c][3]);
    end
    wr(8'hE0, 24'h00_0100);
    for (int p = 0; p < 2; p++) begin
      wr(8'hC0, p ? 24'h00_01FF : 24'h00_0102);
      gap_meas(gap, nst);
      gap_meas(gap, nst);
      chk(gap, (p ? 256 : 3) * CYC_PER_US);
      chk(nst, 8);
    end
    for (int s = 0; s < 2; s++) begin
      DAC_OBSERVE_SELECT = s[0];
      repeat (5) @(negedge REF_CLK);
      chk(SOUND_DATA_PINS, s ? 4'h3 : 4'hA);
    end
    chk(fr, 7);
    for (int m = 0; m < 4; m++) begin
      wr(8'hE0, {16'h0000, 8'(m << 4)});
      for (int k = 0; k < 200 && DISPLAY_ON !== 1'b1; k++) begin
        @(negedge REF_CLK);
      end
      pulse(3'(5 * m + 1), 1'b0, 1'b1);
      pulse(3'(5 * m), 1'b0, 1'b0);
      pulse(3'(5 * m), 1'b1, 1'b1);
    end
    chk(SOUND_DATA_PINS, 4'h6);
    wr(8'hE0, 24'h00_0040);
    repeat (2) @(negedge REF_CLK);
    chk(INTERLACE_ON, 1);
    // Two whole fields once settled: written value W gives 2W+3 rasters, odd field the longer
    repeat (2) @(negedge VERT_SYNC_N);
    gap = 0;
    nst = 0;
    fork
      repeat (2) @(negedge VERT_SYNC_N);
      forever begin
        @(negedge REF_CLK);
        gap++;
        nst += ODD_FIELD;
      end
    join_any
    disable fork;
    chk(gap, (2 * cf[1][0] + 3) * 8);
    chk(nst, (cf[1][0] + 2) * 8);
    for (int t = 1; t < 4; t++) begin
      wr(8'hE0, {8'h00, 2'(t), 14'h0000});
      @(negedge REF_CLK);
      rc0 = RASTER_COUNT;
      @(negedge REF_CLK);
      chk(HCOUNT_TEST_STEP, t == 1);
      if (t > 1) begin
        chk(RASTER_COUNT, t == 2 ? {rc0[9:5], rc0[4:0] + 5'h01} : {rc0[9:5] + 5'h01, rc0[4:0]});
      end
    end
    summarize();
  end
endmodule
